// File: admc_pkg.sv
package admc_pkg;

  // register byte offsets
  localparam logic [7:0] ADMC_SYS_CTRL_OFS = 8'h00;
  localparam logic [7:0] ADMC_IRQ_MASK_OFS = 8'h04;
  localparam logic [7:0] ADMC_IRQ_FLAG_OFS = 8'h08;
  localparam logic [7:0] ADMC_RST_STAT_OFS = 8'h0C;
  localparam logic [7:0] ADMC_MODE_STAT_OFS = 8'h10;

  // system control bit positions
  localparam int ADMC_ALIVE_POS = 0;
  localparam int ADMC_STOP_POS = 1;
  localparam int ADMC_SLEEP_POS = 2;
  localparam int ADMC_WDOG_EN_POS = 3;

  // interrupt mask / flag bit positions (shared layout)
  localparam int ADMC_WAKE_POS = 0;
  localparam int ADMC_LIN_POS = 1;
  localparam int ADMC_LOWV_POS = 2;
  localparam int ADMC_HIGHV_POS = 3;
  localparam int ADMC_TEMP_POS = 4;

  // reset status bit positions
  localparam int ADMC_RS_WAKE_POS = 0;
  localparam int ADMC_RS_LIN_POS = 1;
  localparam int ADMC_RS_POR_POS = 2;

  // reset values
  localparam logic [3:0] ADMC_SYS_CTRL_RST = 4'h0;
  localparam logic [4:0] ADMC_IRQ_MASK_RST = 5'h00;
  localparam logic [4:0] ADMC_IRQ_FLAG_RST = 5'h00;
  localparam logic [2:0] ADMC_RST_STAT_RST = 3'h4;
  // synchroniser lanes start at their pins' idle levels (reset line and lin high)
  localparam logic [7:0] ADMC_SYNC_IDLE = 8'h84;

  // timing
  localparam int ADMC_CLK_MHZ = 100;
  localparam int ADMC_ALIVE_TIMEOUT_MS = 80;
  localparam int ADMC_ALIVE_TIMEOUT_CYC = ADMC_ALIVE_TIMEOUT_MS * 1000 * ADMC_CLK_MHZ;
  localparam int ADMC_LIN_DOM_MIN_US = 50;
  localparam int ADMC_LIN_DOM_MIN_CYC = ADMC_LIN_DOM_MIN_US * ADMC_CLK_MHZ;
  localparam int ADMC_RESET_HOLD_CYC = 16;
  localparam logic [3:0] ADMC_IRQ_PULSE_CYC = 4'h4;

  // operating modes
  typedef enum logic [2:0] {
    ADMC_RESET,
    ADMC_NORM_REQ,
    ADMC_NORMAL,
    ADMC_STOP,
    ADMC_SLEEP
  } admc_mode_type;

  // power control outputs travelling together
  typedef struct packed {
    logic vreg_on;
    logic vreg_limited;
    logic power_stage_en;
    logic lin_active;
    logic lin_wake_detect;
    logic wdog_run;
  } admc_power_type;

endpackage

// File: admc_mode_ctrl.sv
`timescale 1ns/1ns
// Notes on behaviour
// - strap high disables alive timeout and the lin receiver
// - missing alive ack within timeout sends device to sleep
// - normal, stop, sleep modes chosen by stop and sleep control bits
// - normal enables power stages and lin; watchdog runs only if enabled
// - stop needs stop bit and halted mcu; regulator stays on, limited
// - stop wake by lin or wake input, each gated by its enable; irq pulse
// - stop wake source shown in wake input and lin wake flags
// - sleep turns regulator off and holds mcu reset low
// - sleep wake by lin or wake input, unmasked, acts as power-on reset
// - sleep wake source recorded in reset status flags
// - stop and sleep disable power stages, supervision; lin recessive, wake watch
// - events pulse interrupt line; sources maskable via mask register
// - any reset clears all interrupt enables
// - low supply sets flag; interrupt only when enabled
// - low supply detection off in sleep and stop
// - high supply sets flag, interrupts if enabled; off in stop and sleep
// - over temperature sets flag, interrupts if enabled; off in stop and sleep
// - stop lin wake: rising edge after dominant longer than minimum time
// - interrupt output is open drain toward the mcu
module admc_mode_ctrl
  import admc_pkg::*;
#(
  parameter int ALIVE_TIMEOUT_CYC = ADMC_ALIVE_TIMEOUT_CYC,
  parameter int LIN_DOM_MIN_CYC = ADMC_LIN_DOM_MIN_CYC
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // asynchronous pins and analog comparators
  input wire logic factory_strap,
  input wire logic wake_input,
  input wire logic lin_rx,
  input wire logic low_supply_event,
  input wire logic high_supply_event,
  input wire logic over_temp_event,
  input wire logic mcu_halted,
  input wire logic ext_reset_n,
  // mcu reset line, open drain
  output logic mcu_reset_out,
  output logic mcu_reset_oe,
  // interrupt line, open drain
  output logic irq_out,
  output logic irq_oe,
  // power control
  output admc_power_type power_ctrl,
  output logic lin_rx_en
);

  // two-stage synchronisers for all outside inputs
  localparam int NSYNC = 8;
  logic [NSYNC-1:0] sync1_reg;
  logic [NSYNC-1:0] sync2_reg;
  wire [NSYNC-1:0] async_in = {
    ext_reset_n,
    mcu_halted,
    over_temp_event,
    high_supply_event,
    low_supply_event,
    lin_rx,
    wake_input,
    factory_strap
  };
  // idle reset values keep a false lin edge or external reset out of the first cycles
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_reg <= ADMC_SYNC_IDLE;
      sync2_reg <= ADMC_SYNC_IDLE;
    end else begin
      sync1_reg <= async_in;
      sync2_reg <= sync1_reg;
    end
  end
  wire strap_s = sync2_reg[0];
  wire wake_s = sync2_reg[1];
  wire lin_s = sync2_reg[2];
  wire lowv_s = sync2_reg[3];
  wire highv_s = sync2_reg[4];
  wire temp_s = sync2_reg[5];
  wire halted_s = sync2_reg[6];
  wire ext_rst_s = ~sync2_reg[7];

  // ahb-lite address phase capture
  logic wr_pend_reg;
  logic [7:0] addr_reg;
  wire bus_take = hsel & hready & htrans[1];
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      addr_reg <= 8'h00;
    end else begin
      wr_pend_reg <= bus_take & hwrite;
      addr_reg <= bus_take ? haddr : addr_reg;
    end
  end
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // address compare shared by the write strobes and the read mux
  function automatic logic admc_hit(input logic [7:0] addr, input logic [7:0] ofs);
    admc_hit = (addr == ofs);
  endfunction

  // write strobes in the data phase
  wire wr_ctrl = wr_pend_reg & admc_hit(addr_reg, ADMC_SYS_CTRL_OFS);
  wire wr_mask = wr_pend_reg & admc_hit(addr_reg, ADMC_IRQ_MASK_OFS);
  wire wr_flag = wr_pend_reg & admc_hit(addr_reg, ADMC_IRQ_FLAG_OFS);
  wire wr_rstat = wr_pend_reg & admc_hit(addr_reg, ADMC_RST_STAT_OFS);

  // registers and state
  admc_mode_type mode_reg, mode_next;
  logic [3:0] ctrl_reg, ctrl_next;
  logic [4:0] mask_reg, mask_next;
  logic [4:0] flag_reg, flag_next;
  logic [2:0] rstat_reg, rstat_next;
  logic [26:0] tmr_reg, tmr_next;
  logic [19:0] dom_reg, dom_next;
  logic dom_ok_reg;
  logic lin_prev_reg;
  logic wake_prev_reg;
  logic [3:0] pulse_reg, pulse_next;
  logic [31:0] hrdata_reg;

  // mode-dependent enables
  wire in_normal = (mode_reg == ADMC_NORMAL);
  wire in_stop = (mode_reg == ADMC_STOP);
  wire in_sleep = (mode_reg == ADMC_SLEEP);
  wire low_pwr = in_stop | in_sleep;
  wire lin_rx_on = ~strap_s;

  // lin wake: rising edge after long enough dominant (low) period
  wire lin_rise = lin_s & ~lin_prev_reg & lin_rx_on;
  wire lin_wake = lin_rise & dom_ok_reg;
  assign dom_next = lin_s ? 20'h00000 : (dom_ok_reg ? dom_reg : dom_reg + 20'h00001);
  wire wake_edge = wake_s ^ wake_prev_reg;

  // hardware flag sets; supply and temperature detection off in low power modes
  logic [4:0] flag_set;
  always_comb begin
    flag_set = 5'h00;
    flag_set[ADMC_LOWV_POS] = lowv_s & ~low_pwr;
    flag_set[ADMC_HIGHV_POS] = highv_s & ~low_pwr;
    flag_set[ADMC_TEMP_POS] = temp_s & ~low_pwr;
    flag_set[ADMC_WAKE_POS] = wake_edge & (in_normal | (in_stop & mask_reg[ADMC_WAKE_POS]));
    flag_set[ADMC_LIN_POS] = lin_wake & in_stop & mask_reg[ADMC_LIN_POS];
  end

  // any enabled wake source ends stop, even while its flag is still pending,
  // so a flag that software forgot to clear cannot keep the mcu asleep
  wire stop_wake = in_stop & (|flag_set[ADMC_LIN_POS:ADMC_WAKE_POS]);

  // wake from sleep is unmasked
  wire sleep_wake = in_sleep & (wake_edge | lin_wake);

  // flag clear by writing one; set wins over clear
  assign flag_next = (flag_reg & ~(wr_flag ? hwdata[4:0] : 5'h00)) | flag_set;
  assign mask_next = wr_mask ? hwdata[4:0] : mask_reg;
  assign ctrl_next = wr_ctrl ? hwdata[3:0] : ctrl_reg;

  // reset status: sleep wake records its source and marks power-on
  always_comb begin
    rstat_next = rstat_reg & ~(wr_rstat ? hwdata[2:0] : 3'h0);
    if (sleep_wake) begin
      rstat_next = 3'h0;
      rstat_next[ADMC_RS_POR_POS] = 1'b1;
      rstat_next[ADMC_RS_WAKE_POS] = wake_edge;
      rstat_next[ADMC_RS_LIN_POS] = lin_wake;
    end
  end

  // new enabled flag launches the interrupt pulse
  wire [4:0] new_irq = flag_set & ~flag_reg & mask_reg;
  wire irq_launch = (|new_irq) | stop_wake;
  wire [3:0] pulse_dec = (pulse_reg != 4'h0) ? pulse_reg - 4'h1 : 4'h0;
  assign pulse_next = irq_launch ? ADMC_IRQ_PULSE_CYC : pulse_dec;

  // mode sequencer
  always_comb begin
    mode_next = mode_reg;
    tmr_next = tmr_reg + 27'h0000001;
    unique case (mode_reg)
      // hold the mcu in reset for a fixed time, then ask for the alive acknowledge
      ADMC_RESET: begin
        if (ext_rst_s) begin
          tmr_next = 27'h0000000;
        end else if (tmr_reg >= 27'(ADMC_RESET_HOLD_CYC)) begin
          mode_next = ADMC_NORM_REQ;
          tmr_next = 27'h0000000;
        end
      end
      // supervise start-up; the strap holds the timer at zero
      ADMC_NORM_REQ: begin
        if (ctrl_reg[ADMC_ALIVE_POS]) begin
          mode_next = ADMC_NORMAL;
        end else if (!strap_s && tmr_reg >= 27'(ALIVE_TIMEOUT_CYC - 1)) begin
          mode_next = ADMC_SLEEP;
        end
        if (strap_s) begin
          tmr_next = 27'h0000000;
        end
      end
      // run until software asks for a low power mode
      ADMC_NORMAL: begin
        tmr_next = 27'h0000000;
        if (ctrl_reg[ADMC_SLEEP_POS]) begin
          mode_next = ADMC_SLEEP;
        end else if (ctrl_reg[ADMC_STOP_POS] && halted_s) begin
          mode_next = ADMC_STOP;
        end
      end
      // stop ends on an enabled wake source
      ADMC_STOP: begin
        tmr_next = 27'h0000000;
        if (stop_wake) begin
          mode_next = ADMC_NORMAL;
        end
      end
      // sleep ends on any wake source, as a power-on
      ADMC_SLEEP: begin
        tmr_next = 27'h0000000;
        if (sleep_wake) begin
          mode_next = ADMC_RESET;
        end
      end
    endcase
    if (ext_rst_s && mode_reg != ADMC_SLEEP) begin
      mode_next = ADMC_RESET;
      tmr_next = 27'h0000000;
    end
  end

  // entering reset clears control and enables
  wire to_reset = (mode_next == ADMC_RESET) & (mode_reg != ADMC_RESET);

  // leaving stop drops the stop request so the die does not fall straight back in
  wire stop_exit = in_stop & (mode_next == ADMC_NORMAL);
  wire [3:0] ctrl_upd = stop_exit ? (ctrl_next & ~(4'h1 << ADMC_STOP_POS)) : ctrl_next;

  // state registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_reg <= ADMC_RESET;
      tmr_reg <= 27'h0000000;
      ctrl_reg <= ADMC_SYS_CTRL_RST;
      mask_reg <= ADMC_IRQ_MASK_RST;
      flag_reg <= ADMC_IRQ_FLAG_RST;
      rstat_reg <= ADMC_RST_STAT_RST;
    end else begin
      mode_reg <= mode_next;
      tmr_reg <= tmr_next;
      ctrl_reg <= to_reset ? ADMC_SYS_CTRL_RST : ctrl_upd;
      mask_reg <= to_reset ? ADMC_IRQ_MASK_RST : mask_next;
      flag_reg <= to_reset ? ADMC_IRQ_FLAG_RST : flag_next;
      rstat_reg <= rstat_next;
    end
  end

  // edge and dominant-time trackers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dom_reg <= 20'h00000;
      dom_ok_reg <= 1'b0;
      lin_prev_reg <= 1'b1;
      wake_prev_reg <= 1'b0;
      pulse_reg <= 4'h0;
    end else begin
      dom_reg <= dom_next;
      dom_ok_reg <= ~lin_s & (dom_ok_reg | (dom_reg >= 20'(LIN_DOM_MIN_CYC)));
      lin_prev_reg <= lin_s;
      wake_prev_reg <= wake_s;
      pulse_reg <= pulse_next;
    end
  end

  // register read mux
  wire [31:0] rd_mux = admc_hit(haddr, ADMC_SYS_CTRL_OFS) ? {28'h0, ctrl_reg} :
                       admc_hit(haddr, ADMC_IRQ_MASK_OFS) ? {27'h0, mask_reg} :
                       admc_hit(haddr, ADMC_IRQ_FLAG_OFS) ? {27'h0, flag_reg} :
                       admc_hit(haddr, ADMC_RST_STAT_OFS) ? {29'h0, rstat_reg} :
                       admc_hit(haddr, ADMC_MODE_STAT_OFS) ? {28'h0, strap_s, mode_reg} : 32'h0000_0000;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_reg <= 32'h0000_0000;
    end else if (bus_take && !hwrite) begin
      hrdata_reg <= rd_mux;
    end
  end
  assign hrdata = hrdata_reg;

  // open-drain outputs: drive low only
  assign irq_out = 1'b0;
  assign irq_oe = (pulse_reg != 4'h0);
  assign mcu_reset_out = 1'b0;
  assign mcu_reset_oe = (mode_reg == ADMC_RESET) | in_sleep;

  // power control per mode
  assign power_ctrl.vreg_on = ~in_sleep;
  assign power_ctrl.vreg_limited = in_stop;
  assign power_ctrl.power_stage_en = in_normal;
  assign power_ctrl.lin_active = in_normal;
  assign power_ctrl.lin_wake_detect = low_pwr;
  assign power_ctrl.wdog_run = in_normal & ctrl_reg[ADMC_WDOG_EN_POS];
  assign lin_rx_en = lin_rx_on;

endmodule

// File: admc_mode_ctrl_monitor.sv
`timescale 1ns/1ns
module admc_mode_ctrl_monitor
  import admc_pkg::*;
#(parameter int ALIVE_TIMEOUT_CYC = 200) (
  // clock and reset
  input logic hclk,
  input logic hresetn,
  // watched pins
  input logic factory_strap,
  input logic wake_input,
  input logic lin_rx_en,
  input logic irq_out,
  input logic irq_oe,
  input logic mcu_reset_out,
  input logic mcu_reset_oe,
  input admc_power_type power_ctrl
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  int wait_cnt_reg;
  // cycles spent waiting for the alive acknowledge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) wait_cnt_reg <= 0;
    else if (factory_strap || mcu_reset_oe || !power_ctrl.vreg_on || power_ctrl.vreg_limited
             || power_ctrl.power_stage_en) wait_cnt_reg <= 0;
    else wait_cnt_reg <= wait_cnt_reg + 1;
  end
  sequence s_pulse;
    irq_oe [*4] ##1 !irq_oe;
  endsequence
  property p_pulse; $rose(irq_oe) |-> s_pulse; endproperty
  a_pulse: assert property (p_pulse) else $error("irq pulse width wrong");
  property p_od; irq_oe |-> !irq_out; endproperty
  a_od: assert property (p_od) else $error("irq not driven low");
  property p_sleep; !power_ctrl.vreg_on |-> mcu_reset_oe && !mcu_reset_out; endproperty
  a_sleep: assert property (p_sleep) else $error("reset not held in sleep");
  property p_strap; factory_strap [*4] |-> !lin_rx_en; endproperty
  a_strap: assert property (p_strap) else $error("lin receiver on under strap");
  property p_normal; power_ctrl.power_stage_en |-> power_ctrl.lin_active && power_ctrl.vreg_on && !mcu_reset_oe;
  endproperty
  a_normal: assert property (p_normal) else $error("power stages on outside normal");
  property p_wdog; power_ctrl.wdog_run |-> power_ctrl.power_stage_en; endproperty
  a_wdog: assert property (p_wdog) else $error("watchdog runs outside normal");
  property p_quiet; (power_ctrl.vreg_limited || !power_ctrl.vreg_on) |-> power_ctrl.lin_wake_detect
    && !power_ctrl.power_stage_en && !power_ctrl.wdog_run && !power_ctrl.lin_active; endproperty
  a_quiet: assert property (p_quiet) else $error("low power outputs wrong");
  property p_alive; wait_cnt_reg <= ALIVE_TIMEOUT_CYC + 8; endproperty
  a_alive: assert property (p_alive) else $error("alive wait overran");
  property p_wake; !power_ctrl.vreg_on && $changed(wake_input) |-> ##[1:8] power_ctrl.vreg_on; endproperty
  a_wake: assert property (p_wake) else $error("no wake from sleep");
endmodule
bind admc_mode_ctrl admc_mode_ctrl_monitor #(.ALIVE_TIMEOUT_CYC(ALIVE_TIMEOUT_CYC)) i_admc_mode_ctrl_monitor (
  .hclk, .hresetn, .factory_strap, .wake_input, .lin_rx_en, .irq_out, .irq_oe, .mcu_reset_out,
  .mcu_reset_oe, .power_ctrl);

// File: admc_mcu_model.sv
`timescale 1ns/1ns
module admc_mcu_model (
  // open drain lines from the die
  input logic irq_out,
  input logic irq_oe,
  input logic mcu_reset_out,
  input logic mcu_reset_oe,
  // stop request from the bench
  input logic stop_req,
  // resolved lines and cpu state
  output logic irq_n,
  output logic rst_n,
  output logic mcu_halted,
  output int irq_count
);
  // pull-ups win when nobody drives
  assign irq_n = irq_oe ? irq_out : 1'b1;
  assign rst_n = mcu_reset_oe ? mcu_reset_out : 1'b1;
  // cpu halts itself only when running and asked to stop
  assign mcu_halted = stop_req && rst_n;
  // count interrupt pulses
  always @(negedge irq_n) irq_count++;
endmodule

// File: admc_mode_ctrl_tb.sv
`timescale 1ns/1ns
module admc_mode_ctrl_tb;
  import admc_pkg::*;
  typedef struct {logic w; logic [7:0] a; logic [31:0] d;} admc_row_type;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, factory_strap = 0, wake_input = 0, lin_rx = 1, stop_req = 0;
  logic [2:0] sup = 3'h0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic [31:0] hwdata = 32'h0, hrdata, rd;
  logic hreadyout, hresp, mcu_halted, mcu_reset_out, mcu_reset_oe, irq_out, irq_oe, lin_rx_en, irq_n, rst_n;
  admc_power_type power_ctrl;
  int num_errors = 0, num_checks = 0, irq_count, n0;
  admc_row_type rows [8] = '{'{0, 8'h04, 32'h0}, '{0, 8'h0C, 32'h4}, '{0, 8'h10, {29'h0, ADMC_NORM_REQ}},
    '{1, 8'h00, 32'h1}, '{0, 8'h10, {29'h0, ADMC_NORMAL}}, '{1, 8'h04, 32'h17}, '{0, 8'h04, 32'h17},
    '{0, 8'h14, 32'h0}};
  admc_mode_ctrl #(.ALIVE_TIMEOUT_CYC(200), .LIN_DOM_MIN_CYC(20)) i_admc_mode_ctrl (.hclk, .hresetn, .hsel,
    .haddr, .htrans, .hwrite, .hsize(3'h2), .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp,
    .factory_strap, .wake_input, .lin_rx, .low_supply_event(sup[0]), .high_supply_event(sup[1]),
    .over_temp_event(sup[2]), .mcu_halted, .ext_reset_n(1'b1), .mcu_reset_out, .mcu_reset_oe, .irq_out,
    .irq_oe, .power_ctrl, .lin_rx_en);
  admc_mcu_model i_admc_mcu_model (.irq_out, .irq_oe, .mcu_reset_out, .mcu_reset_oe, .stop_req, .irq_n,
    .rst_n, .mcu_halted, .irq_count);
  always #5 hclk = ~hclk;
  task automatic wt(input int n);
    repeat (n) @(posedge hclk);
  endtask
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask
  // one single ahb transfer, held until ready
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic rdc(input string s, input logic [7:0] a, input logic [31:0] e);
    bus(0, a, 32'h0);
    chk(s, e, rd);
  endtask
  task automatic md(input admc_mode_type m);
    rdc("mode", 8'h10, {28'h0, factory_strap, m});
  endtask
  task automatic give_verdict;
    if (num_errors == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // cut a hang short
  initial begin
    #300000;
    num_errors++;
    give_verdict;
  end
  // main sequence
  initial begin
    wt(6);
    hresetn <= 1;
    wt(25);
    foreach (rows[i]) begin
      if (rows[i].w) bus(1, rows[i].a, rows[i].d);
      else rdc("row", rows[i].a, rows[i].d);
    end
    chk("pwr", 32'h2C, power_ctrl);
    bus(1, 8'h00, 32'h9);
    wt(1);
    chk("pwr", 32'h2D, power_ctrl);
    for (int i = 0; i < 3; i++) begin
      n0 = irq_count;
      sup <= 3'(1 << i);
      wt(10);
      chk("irq", n0 + (i != 1), irq_count);
      sup <= 3'h0;
      wt(4);
      rdc("flag", 8'h08, 32'(4 << i));
      bus(1, 8'h08, 32'h1C);
    end
    for (int i = 0; i < 2; i++) begin
      bus(1, 8'h00, 32'h3);
      stop_req <= 1;
      wt(6);
      md(ADMC_STOP);
      chk("pwr", 32'h32, power_ctrl);
      n0 = irq_count;
      sup <= 3'h1;
      wt(6);
      sup <= 3'h0;
      if (i == 0) wake_input <= 1;
      else lin_rx <= 0;
      wt(30);
      lin_rx <= 1;
      wt(10);
      chk("irq", n0 + 1, irq_count);
      stop_req <= 0;
      md(ADMC_NORMAL);
      rdc("flag", 8'h08, 32'(1 << i));
      bus(1, 8'h08, 32'h1F);
    end
    bus(1, 8'h00, 32'h5);
    wt(4);
    chk("rst", 0, rst_n);
    chk("pwr", 32'h02, power_ctrl);
    wake_input <= 0;
    wt(40);
    md(ADMC_NORM_REQ);
    bus(0, 8'h0C, 32'h0);
    chk("cause", 1, rd[1:0]);
    rdc("mask", 8'h04, 32'h0);
    wt(220);
    md(ADMC_SLEEP);
    lin_rx <= 0;
    wt(30);
    lin_rx <= 1;
    wt(40);
    bus(0, 8'h0C, 32'h0);
    chk("cause", 2, rd[1:0]);
    bus(1, 8'h04, 32'h1F);
    factory_strap <= 1;
    hresetn <= 0;
    wt(6);
    hresetn <= 1;
    wt(260);
    md(ADMC_NORM_REQ);
    chk("lin_en", 0, lin_rx_en);
    rdc("mask", 8'h04, 32'h0);
    give_verdict;
  end
endmodule
